/* File: logic/slcs_consts.svh */
// Address offsets, field positions and reset values of the serial line clock select glue.
`ifndef SLCS_CONSTS_SVH
`define SLCS_CONSTS_SVH
`define SLCS_OFS_V35_SEL 32'h0000_4000
`define SLCS_OFS_530_SEL 32'h0000_5000
`define SLCS_OFS_TXT_OUT 32'h0000_6000
`define SLCS_OFS_TXT_IN 32'h0000_7000
`define SLCS_OFS_STATUS 32'h0000_8000
`define SLCS_ADDR_BOARD_ID 32'hff70_0000
`define SLCS_STATUS_V35_BIT 0
`define SLCS_STATUS_TXT_IN_BIT 1
`define SLCS_RDATA_RESET 32'h0000_0000
`define SLCS_PORTS_DEFAULT 8
`endif

/* File: logic/slcs_pkg.sv */
// Types shared by the serial line clock select glue.
package slcs_pkg;
  // Line signalling standard applied to every port together.
  typedef enum logic {SLCS_IF_EIA530A, SLCS_IF_V35} slcs_iface_type;
  // Direction of the shared transmit timing signal.
  typedef enum logic {SLCS_TXT_OUTPUT, SLCS_TXT_INPUT} slcs_txdir_type;
  // One bus data word.
  typedef logic [31:0] slcs_word_type;
endpackage

/* File: logic/slcs_sync.sv */
// Two flip-flop synchroniser for a group of line inputs.
`timescale 1ns/1ps
`default_nettype none
module slcs_sync #(
  parameter int W = 1
) (
  input wire logic i_ref_clk, // System clock.
  input wire logic i_sys_rst, // Synchronous reset, active high.
  input wire logic [W-1:0] i_async, // Inputs from outside the clock domain.
  output logic [W-1:0] o_sync // Synchronised copies.
);
  logic [W-1:0] stage1_reg; // First stage, read only by the second stage.
  logic [W-1:0] stage2_reg; // Second stage, safe to use.

  // Both stages clear on reset and then shift the inputs in.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
    end
  end

  assign o_sync = stage2_reg;
endmodule
`default_nettype wire

/* File: logic/slcs_glue.sv */
// Serial line clock select glue: interface select, timing direction, lamps and board id.
// Operation
// R1: Reset makes transmit timing an output.
// R2: Access at offset 7000 makes timing input.
// R3: Access at offset 6000 makes timing output.
// R4: One timing direction shared by all ports.
// R5: Receive timing is always an input.
// R6: Exactly one lamp shows selected interface.
// R7: Read-only board id at FF700000.
// R8: Ports behave as terminal equipment.
// R9: Reset selects EIA-BALANCED_INTERFACE_LAMP signalling.
// R10: Access at offset 4000 selects V.35.
// R11: Access at offset 5000 selects EIA-BALANCED_INTERFACE_LAMP.
// R12: Repeat accesses idempotent; select reads return zero.
`timescale 1ns/1ps
`default_nettype none
`include "slcs_consts.svh"
module slcs_glue #(
  parameter int N = `SLCS_PORTS_DEFAULT, // Number of serial ports.
  parameter logic [31:0] ADAPTER_WINDOW_BASE = 32'h0000_0000, // Base of the adapter window.
  parameter logic [31:0] BOARD_ID = 32'h5a3c_0001 // Board identification, arbitrary value.
) (
  input wire logic i_ref_clk, // System clock, 10 MHz.
  input wire logic i_sys_rst, // Synchronous reset, active high.
  input wire logic [31:0] i_addr, // Bus address.
  input wire logic [31:0] i_wdata, // Bus write data, ignored by this block.
  input wire logic i_wr, // Write strobe.
  input wire logic i_rd, // Read strobe.
  output logic [31:0] o_rdata, // Read data, one cycle after the read strobe.
  output logic o_v35_lamp, // V.35 indicator lamp.
  output logic o_balanced_interface_lamp, // EIA-BALANCED_INTERFACE_LAMP indicator lamp.
  input wire logic [N-1:0] i_ctl_tx_data, // Transmit data from the serial controller.
  input wire logic [N-1:0] i_ctl_send_request, // Request to send from the serial controller.
  input wire logic [N-1:0] i_ctl_tx_timing, // Transmit timing from the controller.
  output logic [N-1:0] o_ctl_tx_timing, // Transmit timing taken from the line.
  output logic [N-1:0] o_ctl_rx_data, // Received data to the controller.
  output logic [N-1:0] o_ctl_send_clear, // Clear to send to the controller.
  output logic [N-1:0] o_ctl_carrier_detect, // Carrier detect to the controller.
  output logic [N-1:0] o_ctl_rx_timing, // Receive timing to the controller.
  output logic [N-1:0] o_ctl_rx_timing_rise, // One-cycle pulse on a rising receive timing edge.
  output logic [N-1:0] o_tx_serial_pos, // Transmit data, true side.
  output logic [N-1:0] o_tx_serial_neg, // Transmit data, inverted side.
  output logic [N-1:0] o_send_request_pos, // Request to send, true side.
  output logic [N-1:0] o_send_request_neg, // Request to send, inverted side.
  input wire logic [N-1:0] i_tx_timing_pos, // Transmit timing pin level, true side.
  input wire logic [N-1:0] i_tx_timing_neg, // Transmit timing pin level, inverted side.
  output logic [N-1:0] o_tx_timing_pos, // Transmit timing drive, true side.
  output logic [N-1:0] o_tx_timing_neg, // Transmit timing drive, inverted side.
  output logic [N-1:0] o_tx_timing_oe_n, // Transmit timing enable, low while driving.
  input wire logic [N-1:0] i_rx_timing_pos, // Receive timing, true side.
  input wire logic [N-1:0] i_rx_timing_neg, // Receive timing, inverted side.
  input wire logic [N-1:0] i_rx_serial_pos, // Receive data, true side.
  input wire logic [N-1:0] i_rx_serial_neg, // Receive data, inverted side.
  input wire logic [N-1:0] i_send_clear_pos, // Clear to send, true side.
  input wire logic [N-1:0] i_send_clear_neg, // Clear to send, inverted side.
  input wire logic [N-1:0] i_carrier_detect_pos, // Carrier detect, true side.
  input wire logic [N-1:0] i_carrier_detect_neg // Carrier detect, inverted side.
);
  // The whole state of the block.
  typedef struct packed {
    slcs_pkg::slcs_iface_type iface; // Selected line signalling.
    slcs_pkg::slcs_txdir_type txdir; // Shared transmit timing direction.
    slcs_pkg::slcs_word_type rdata; // Read data register.
    logic lamp_v35; // V.35 lamp drive.
    logic lamp_530; // EIA-BALANCED_INTERFACE_LAMP lamp drive.
    logic [N-1:0] tx_ser_pos; // Transmit data drive, true side.
    logic [N-1:0] tx_ser_neg; // Transmit data drive, inverted side.
    logic [N-1:0] req_pos; // Request to send, true side.
    logic [N-1:0] req_neg; // Request to send, inverted side.
    logic [N-1:0] txt_pos; // Transmit timing drive, true side.
    logic [N-1:0] txt_neg; // Transmit timing drive, inverted side.
    logic [N-1:0] txt_oe_n; // Transmit timing enable, low while driving.
    logic [N-1:0] ctl_txt; // Line transmit timing to the controller.
    logic [N-1:0] ctl_rxd; // Received data to the controller.
    logic [N-1:0] ctl_cts; // Clear to send to the controller.
    logic [N-1:0] ctl_dcd; // Carrier detect to the controller.
    logic [N-1:0] ctl_rxt; // Receive timing to the controller.
    logic [N-1:0] ctl_rise; // Receive timing rising edge pulse.
  } slcs_state_type;

  slcs_state_type state_reg; // Registered state.
  slcs_state_type state_next; // Next state.

  logic [10*N-1:0] line_sync; // All line inputs after two flip-flops.
  logic [N-1:0] s_txt_pos; // Synchronised transmit timing, true side.
  logic [N-1:0] s_txt_neg; // Synchronised transmit timing, inverted side.
  logic [N-1:0] s_rxt_pos; // Synchronised receive timing, true side.
  logic [N-1:0] s_rxt_neg; // Synchronised receive timing, inverted side.
  logic [N-1:0] s_rxd_pos; // Synchronised receive data, true side.
  logic [N-1:0] s_rxd_neg; // Synchronised receive data, inverted side.
  logic [N-1:0] s_cts_pos; // Synchronised clear to send, true side.
  logic [N-1:0] s_cts_neg; // Synchronised clear to send, inverted side.
  logic [N-1:0] s_dcd_pos; // Synchronised carrier detect, true side.
  logic [N-1:0] s_dcd_neg; // Synchronised carrier detect, inverted side.
  logic access; // A read or write strobe is present.

  // Every line input passes two flip-flops before any logic reads it.
  slcs_sync #(
    .W(10*N)
  ) u_line_sync (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_tx_timing_pos, i_tx_timing_neg, i_rx_timing_pos, i_rx_timing_neg,
              i_rx_serial_pos, i_rx_serial_neg, i_send_clear_pos, i_send_clear_neg,
              i_carrier_detect_pos, i_carrier_detect_neg}),
    .o_sync(line_sync)
  );

  assign {s_txt_pos, s_txt_neg, s_rxt_pos, s_rxt_neg, s_rxd_pos, s_rxd_neg,
          s_cts_pos, s_cts_neg, s_dcd_pos, s_dcd_neg} = line_sync;
  assign access = i_wr | i_rd;

  // Decodes bus accesses and computes all line and controller outputs.
  always_comb begin
    state_next = state_reg;
    state_next.rdata = `SLCS_RDATA_RESET;
    // Address decode: any access to a select offset changes the shared setting.
    if (access && i_addr == ADAPTER_WINDOW_BASE + `SLCS_OFS_V35_SEL) begin
      state_next.iface = slcs_pkg::SLCS_IF_V35; // R10 R12
    end else if (access && i_addr == ADAPTER_WINDOW_BASE + `SLCS_OFS_530_SEL) begin
      state_next.iface = slcs_pkg::SLCS_IF_EIA530A; // R11 R12
    end else if (access && i_addr == ADAPTER_WINDOW_BASE + `SLCS_OFS_TXT_OUT) begin
      state_next.txdir = slcs_pkg::SLCS_TXT_OUTPUT; // R3 R12
    end else if (access && i_addr == ADAPTER_WINDOW_BASE + `SLCS_OFS_TXT_IN) begin
      state_next.txdir = slcs_pkg::SLCS_TXT_INPUT; // R2 R12
    end else if (i_rd && i_addr == ADAPTER_WINDOW_BASE + `SLCS_OFS_STATUS) begin
      // Status read shows the current selections.
      state_next.rdata[`SLCS_STATUS_V35_BIT] = (state_reg.iface == slcs_pkg::SLCS_IF_V35);
      state_next.rdata[`SLCS_STATUS_TXT_IN_BIT] = (state_reg.txdir == slcs_pkg::SLCS_TXT_INPUT);
    end else if (i_rd && i_addr == `SLCS_ADDR_BOARD_ID) begin
      // Board id is fixed; a write to it decodes to nothing.
      state_next.rdata = BOARD_ID; // R7
    end
    // Lamps follow the registered selection, one lit at a time.
    state_next.lamp_v35 = (state_next.iface == slcs_pkg::SLCS_IF_V35); // R6
    state_next.lamp_530 = (state_next.iface == slcs_pkg::SLCS_IF_EIA530A); // R6
    // Terminal equipment: drive data and request, receive the rest.
    state_next.tx_ser_pos = i_ctl_tx_data; // R8
    state_next.tx_ser_neg = ~i_ctl_tx_data; // R8
    state_next.req_pos = i_ctl_send_request; // R8
    if (state_next.iface == slcs_pkg::SLCS_IF_V35) begin
      // V.35 control signals are single ended on the true side.
      state_next.req_neg = '0;
      state_next.ctl_cts = s_cts_pos; // R8
      state_next.ctl_dcd = s_dcd_pos; // R8
    end else begin
      // EIA-BALANCED_INTERFACE_LAMP is balanced for every signal.
      state_next.req_neg = ~i_ctl_send_request;
      state_next.ctl_cts = s_cts_pos & ~s_cts_neg; // R8
      state_next.ctl_dcd = s_dcd_pos & ~s_dcd_neg; // R8
    end
    state_next.ctl_rxd = s_rxd_pos & ~s_rxd_neg; // R8
    // Receive timing is only ever read from the line; its rising edges are found here.
    state_next.ctl_rxt = s_rxt_pos & ~s_rxt_neg; // R5
    state_next.ctl_rise = state_next.ctl_rxt & ~state_reg.ctl_rxt; // R5
    // One direction bit steers the transmit timing pins of every port.
    if (state_next.txdir == slcs_pkg::SLCS_TXT_OUTPUT) begin
      state_next.txt_oe_n = '0; // R4
      state_next.txt_pos = i_ctl_tx_timing;
      state_next.txt_neg = ~i_ctl_tx_timing;
      state_next.ctl_txt = '0;
    end else begin
      state_next.txt_oe_n = '1; // R4
      state_next.txt_pos = '0;
      state_next.txt_neg = '0;
      state_next.ctl_txt = s_txt_pos & ~s_txt_neg;
    end
  end

  // Registers the state; reset selects EIA-BALANCED_INTERFACE_LAMP and driven transmit timing.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_reg <= '0;
      state_reg.iface <= slcs_pkg::SLCS_IF_EIA530A; // R9
      state_reg.txdir <= slcs_pkg::SLCS_TXT_OUTPUT; // R1
      state_reg.lamp_530 <= 1'b1; // R6
      state_reg.tx_ser_neg <= '1;
      state_reg.req_neg <= '1;
      state_reg.txt_neg <= '1;
      state_reg.txt_oe_n <= '0; // R1
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state register.
  assign o_rdata = state_reg.rdata;
  assign o_v35_lamp = state_reg.lamp_v35;
  assign o_balanced_interface_lamp = state_reg.lamp_530;
  assign o_ctl_tx_timing = state_reg.ctl_txt;
  assign o_ctl_rx_data = state_reg.ctl_rxd;
  assign o_ctl_send_clear = state_reg.ctl_cts;
  assign o_ctl_carrier_detect = state_reg.ctl_dcd;
  assign o_ctl_rx_timing = state_reg.ctl_rxt;
  assign o_ctl_rx_timing_rise = state_reg.ctl_rise;
  assign o_tx_serial_pos = state_reg.tx_ser_pos;
  assign o_tx_serial_neg = state_reg.tx_ser_neg;
  assign o_send_request_pos = state_reg.req_pos;
  assign o_send_request_neg = state_reg.req_neg;
  assign o_tx_timing_pos = state_reg.txt_pos;
  assign o_tx_timing_neg = state_reg.txt_neg;
  assign o_tx_timing_oe_n = state_reg.txt_oe_n;
endmodule
`default_nettype wire

/* File: tb/slcs_glue_sva.sv */
// Checker for select strobes, lamps, timing direction, board id and line drive of the glue.
`timescale 1ns/1ps
`default_nettype none
module slcs_glue_sva #(
  parameter int N = 8,
  parameter logic [31:0] ADAPTER_WINDOW_BASE = 32'h0000_0000,
  parameter logic [31:0] BOARD_ID = 32'h0000_0000
) (
  input wire logic i_ref_clk, // Clock.
  input wire logic i_sys_rst, // Reset.
  input wire logic [31:0] i_addr, // Address.
  input wire logic i_wr, // Write strobe.
  input wire logic i_rd, // Read strobe.
  input wire logic [31:0] o_rdata, // Read data.
  input wire logic o_v35_lamp, // V.35 lamp.
  input wire logic o_balanced_interface_lamp, // EIA-BALANCED_INTERFACE_LAMP lamp.
  input wire logic [N-1:0] o_tx_timing_oe_n, // Timing enable.
  input wire logic [N-1:0] i_ctl_tx_data, // Controller data.
  input wire logic [N-1:0] o_tx_serial_pos, // Line data, true side.
  input wire logic [N-1:0] o_tx_serial_neg // Line data, inverted side.
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // Access flag and offset inside the adapter window.
  logic acc;
  logic [31:0] ofs;
  assign acc = i_wr | i_rd;
  assign ofs = i_addr - ADAPTER_WINDOW_BASE;
  chk_lamp_onehot: assert property (o_v35_lamp != o_balanced_interface_lamp)
    else $error("lamps not exclusive");
  chk_reset_state: assert property ($fell(i_sys_rst) |-> o_balanced_interface_lamp && o_tx_timing_oe_n == '0)
    else $error("bad state after reset");
  chk_v35_select: assert property (acc && ofs == 32'h0000_4000 |=> o_v35_lamp)
    else $error("v35 not selected");
  chk_530_select: assert property (acc && ofs == 32'h0000_5000 |=> o_balanced_interface_lamp)
    else $error("530 not selected");
  chk_timing_input: assert property (acc && ofs == 32'h0000_7000 |=> &o_tx_timing_oe_n)
    else $error("timing not released");
  chk_timing_output: assert property (acc && ofs == 32'h0000_6000 |=> o_tx_timing_oe_n == '0)
    else $error("timing not driven");
  chk_shared_dir: assert property (o_tx_timing_oe_n == '0 || &o_tx_timing_oe_n)
    else $error("directions differ");
  chk_setting_hold: assert property (!(acc && ofs inside {32'h4000, 32'h5000, 32'h6000, 32'h7000})
    |=> $stable(o_v35_lamp) && $stable(o_tx_timing_oe_n)) else $error("setting changed");
  chk_id_read: assert property (i_rd && i_addr == 32'hff70_0000 |=> o_rdata == BOARD_ID)
    else $error("bad board id");
  chk_tx_drive: assert property (!$past(i_sys_rst) |-> o_tx_serial_pos == $past(i_ctl_tx_data)
    && o_tx_serial_neg == ~o_tx_serial_pos) else $error("bad line data");
endmodule
`default_nettype wire

/* File: tb/slcs_dce_model.sv */
// Far-end line equipment model: receive lines and transmit timing when released.
`timescale 1ns/1ps
`default_nettype none
module slcs_dce_model #(
  parameter int N = 2
) (
  input wire logic [N-1:0] i_level, // Level to send on data and controls.
  input wire logic [N-1:0] i_oe_n, // Glue timing enable, low while driving.
  input wire logic [N-1:0] i_drv, // Glue timing drive, true side.
  output logic [N-1:0] o_rxt_pos, // Receive timing, true side.
  output logic [N-1:0] o_rxt_neg, // Receive timing, inverted side.
  output logic [N-1:0] o_dat_pos, // Data and controls, true side.
  output logic [N-1:0] o_dat_neg, // Data and controls, inverted side.
  output logic [N-1:0] o_txt_pos, // Transmit timing pin, true side.
  output logic [N-1:0] o_txt_neg // Transmit timing pin, inverted side.
);
  // Line clock of 800 ns, phase unrelated to the system clock.
  logic lclk = 1'b0;
  initial begin
    #37;
    forever #400 lclk = ~lclk;
  end
  // Receive timing always comes from this side.
  assign o_rxt_pos = {N{lclk}};
  assign o_rxt_neg = ~o_rxt_pos;
  assign o_dat_pos = i_level;
  assign o_dat_neg = ~i_level;
  // Pin carries our clock once the glue lets go, else the glue's drive.
  assign o_txt_pos = (i_oe_n & {N{lclk}}) | (~i_oe_n & i_drv);
  assign o_txt_neg = ~o_txt_pos;
endmodule
`default_nettype wire

/* File: tb/tb_serial_line_clock_select_glue.sv */
// Self-checking bench of the serial line clock select glue.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); end end
module tb_serial_line_clock_select_glue;
  localparam int N = 2;
  localparam logic [31:0] BASE = 32'h0001_0000;
  localparam logic [31:0] ID = 32'h1234_abcd; // Arbitrary id value.
  // Bench drives and design outputs.
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, v35, l530;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, d;
  logic [N-1:0] txd = '0, rts = 2'b01, ttc = 2'b11, lvl = '0;
  logic [N-1:0] ctxt, rxd, cts, dcd, rxt, rise, sp, sn, rp, rn, tp, tn, oe_n;
  logic [N-1:0] rxtp, rxtn, dp, dn, ptp, ptn;
  int fail_count = 0, total_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  slcs_glue #(.N(N), .ADAPTER_WINDOW_BASE(BASE), .BOARD_ID(ID)) i_dut (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_v35_lamp(v35),
    .o_balanced_interface_lamp(l530), .i_ctl_tx_data(txd), .i_ctl_send_request(rts), .i_ctl_tx_timing(ttc),
    .o_ctl_tx_timing(ctxt), .o_ctl_rx_data(rxd), .o_ctl_send_clear(cts), .o_ctl_carrier_detect(dcd),
    .o_ctl_rx_timing(rxt), .o_ctl_rx_timing_rise(rise), .o_tx_serial_pos(sp), .o_tx_serial_neg(sn),
    .o_send_request_pos(rp), .o_send_request_neg(rn), .i_tx_timing_pos(ptp), .i_tx_timing_neg(ptn),
    .o_tx_timing_pos(tp), .o_tx_timing_neg(tn), .o_tx_timing_oe_n(oe_n), .i_rx_timing_pos(rxtp),
    .i_rx_timing_neg(rxtn), .i_rx_serial_pos(dp), .i_rx_serial_neg(dn), .i_send_clear_pos(dp),
    .i_send_clear_neg(dn), .i_carrier_detect_pos(dp), .i_carrier_detect_neg(dn));
  slcs_dce_model #(.N(N)) i_dce (.i_level(lvl), .i_oe_n(oe_n), .i_drv(tp), .o_rxt_pos(rxtp), .o_rxt_neg(rxtn),
    .o_dat_pos(dp), .o_dat_neg(dn), .o_txt_pos(ptp), .o_txt_neg(ptn));
  // One bus access; returns the read data of the following cycle.
  task automatic acc(input logic w, input logic [31:0] a);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= ~a;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Counts timing rises over 80 cycles, ten line periods.
  task automatic t_count(input logic [7:0] exp_tx);
    logic [7:0] nr, nt, nh;
    logic last;
    nr = 0;
    nt = 0;
    nh = 0;
    last = ctxt[0];
    repeat (80) begin
      @(posedge clk);
      #1 nr = nr + rise[0];
      nh = nh + rxt[0];
      nt = nt + (ctxt[0] & !last);
      last = ctxt[0];
    end
    `CHK(nr, 8'h0a);
    `CHK(nh, 8'h28);
    `CHK(nt, exp_tx);
  endtask
  // Every select offset: 4000 and 7000 by write and by read, 5000 by read only, 6000 by write only.
  task automatic t_select;
    acc(1'b1, BASE + 32'h4000);
    `CHK({v35, l530}, 2'b10);
    `CHK(rn, 2'b00);
    acc(1'b0, BASE + 32'h8000);
    `CHK(d, 32'h0000_0001);
    acc(1'b0, BASE + 32'h4000);
    `CHK(d, 32'h0);
    `CHK({v35, l530}, 2'b10);
    acc(1'b0, BASE + 32'h5000);
    `CHK({v35, l530}, 2'b01);
    acc(1'b0, BASE + 32'h7000);
    `CHK(oe_n, 2'b11);
    acc(1'b0, BASE + 32'h8000);
    `CHK(d, 32'h0000_0002);
    acc(1'b1, BASE + 32'h7000);
    `CHK(oe_n, 2'b11);
    t_count(8'h0a);
    acc(1'b1, BASE + 32'h6000);
    `CHK(oe_n, 2'b00);
  endtask
  // Board id, a write to it, and an unmapped read.
  task automatic t_id;
    acc(1'b0, 32'hff70_0000);
    `CHK(d, ID);
    acc(1'b1, 32'hff70_0000);
    acc(1'b0, 32'hff70_0000);
    `CHK(d, ID);
    acc(1'b0, BASE + 32'h3000);
    `CHK(d, 32'h0);
  endtask
  // Terminal-side line directions.
  task automatic t_line;
    @(posedge clk);
    txd <= 2'b10;
    lvl <= 2'b01;
    repeat (4) @(posedge clk);
    #1 `CHK({sp, sn, rp}, 6'b10_01_01);
    `CHK({rxd, cts, dcd}, 6'b01_01_01);
    `CHK(rn, 2'b10);
  endtask
  task automatic print_verdict;
    $display("checks %0d, errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1 `CHK({v35, l530, oe_n, tp, tn}, 8'b01_00_00_11);
    t_count(8'h00);
    `CHK({tp, tn}, {ttc, ~ttc});
    t_select();
    t_id();
    t_line();
    print_verdict();
  end
endmodule
bind slcs_glue slcs_glue_sva #(.N(N), .ADAPTER_WINDOW_BASE(ADAPTER_WINDOW_BASE), .BOARD_ID(BOARD_ID)) i_sva (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_v35_lamp(o_v35_lamp), .o_balanced_interface_lamp(o_balanced_interface_lamp),
  .o_tx_timing_oe_n(o_tx_timing_oe_n), .i_ctl_tx_data(i_ctl_tx_data), .o_tx_serial_pos(o_tx_serial_pos),
  .o_tx_serial_neg(o_tx_serial_neg));
`default_nettype wire
